//--- hdl/dcr_channel_regs.sv
`timescale 1ns/1ns
`include "dcr_map.svh"
module dcr_channel_regs (
  input wire logic clock, // System clock, 10 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire dcr_pkg::dcr_wr_t hostWr, // Write request from serial port
  input wire logic [4:0] rdAddr, // Read address from serial port
  input wire logic updatePin, // Update strobe pin, asynchronous
  input wire logic sweepEn, // Linear sweep enable
  input wire logic sweepReload, // Sweep timer reloads on update
  input wire logic sweepUp, // Sweep direction, high is rising
  input wire logic amplitudeRamping, // Ramp up when high, down when low
  input wire logic [9:0] coreSample, // Sample from the synthesis core
  output logic [31:0] rdData, // Read data, registered
  output logic [31:0] freqWord, // Tuning word with sweep offset
  output logic [13:0] phaseOffset, // Active phase offset word
  output logic [9:0] sampleOut, // Scaled or bypassed sample
  output logic ampClkEn, // Clock enable of scaling logic
  output logic updatePulse // One cycle per accepted update
);
  import dcr_pkg::*;

  dcr_state_t st_reg;
  dcr_state_t st_next;
  logic mulEn;
  logic autoRamp;
  logic ampTick;
  logic sweepTick;
  logic [7:0] sweepRate;
  logic [10:0] stepSize;
  logic [10:0] ampSum;
  logic [9:0] scale;
  logic [9:0] factor;
  logic [19:0] product;
  logic [31:0] wrMasked;

  ////////////////////////////////////////////////////////////////////
  // Decoded active fields
  // multiplier enable bit
  assign mulEn = st_reg.active.ampCtl[`DCR_AMPC_MUL_EN];
  assign autoRamp = mulEn && st_reg.active.ampCtl[`DCR_AMPC_AUTO];
  assign scale =
    st_reg.active.ampCtl[`DCR_AMPC_SCALE_HI:`DCR_AMPC_SCALE_LO];
  assign stepSize = `DCR_STEP_ONE <<
    st_reg.active.ampCtl[`DCR_AMPC_STEP_HI:`DCR_AMPC_STEP_LO];
  assign sweepRate = sweepUp ?
    st_reg.active.sweepRates[`DCR_SWR_RISE_HI:`DCR_SWR_RISE_LO] :
    st_reg.active.sweepRates[`DCR_SWR_FALL_HI:`DCR_SWR_FALL_LO];

  // Update counts once the second and third stages agree on high
  assign updatePulse = (st_reg.updSync[1] == st_reg.updSync[2]) &&
    st_reg.updSync[2] && !st_reg.updLvl;

  // Stopping the scaling clock saves power when unused
  assign ampClkEn = mulEn;
  assign factor = autoRamp ? st_reg.ampNow : scale;
  assign product = coreSample * factor;

  ////////////////////////////////////////////////////////////////////
  // Write data masked to the bits each register implements
  always_comb begin
    case (hostWr.addr)
      `DCR_ADDR_POW: wrMasked = hostWr.data & `DCR_MASK_POW;
      `DCR_ADDR_AMP: wrMasked = hostWr.data & `DCR_MASK_AMP;
      `DCR_ADDR_SWRATE: wrMasked = hostWr.data & `DCR_MASK_SWRATE;
      default: wrMasked = hostWr.data & `DCR_MASK_FULL;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Ramp timers: amplitude runs only in automatic mode
  // amplitude ramp timer
  dcr_ramp_timer #(.W(8)) ampTimer (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .run(autoRamp),
    .rate(st_reg.active.ampCtl[`DCR_AMPC_RATE_HI:`DCR_AMPC_RATE_LO]),
    .reloadOnUpd(st_reg.active.ampCtl[`DCR_AMPC_RELOAD]),
    .update(updatePulse),
    .tick(ampTick)
  );

  dcr_ramp_timer #(.W(8)) sweepTimer (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .run(sweepEn),
    .rate(sweepRate),
    .reloadOnUpd(sweepReload),
    .update(updatePulse),
    .tick(sweepTick)
  );

  ////////////////////////////////////////////////////////////////////
  // Next state of the whole bank
  always_comb begin
    st_next = st_reg;
    ampSum = '0;
    st_next.updSync = {st_reg.updSync[1:0], updatePin};
    if (st_reg.updSync[1] == st_reg.updSync[2]) begin
      st_next.updLvl = st_reg.updSync[2];
    end
    // Shadow writes; the datapath never sees half a new setting
    if (hostWr.wr) begin
      case (hostWr.addr)
        `DCR_ADDR_FTW: st_next.shadow.ftw = wrMasked;
        `DCR_ADDR_POW: st_next.shadow.pow = wrMasked;
        `DCR_ADDR_AMP: st_next.shadow.ampCtl = wrMasked;
        `DCR_ADDR_SWRATE: st_next.shadow.sweepRates = wrMasked;
        `DCR_ADDR_RISE: st_next.shadow.riseDelta = wrMasked;
        `DCR_ADDR_FALL: st_next.shadow.fallDelta = wrMasked;
        default: ;
      endcase
    end
    if (updatePulse) begin
      st_next.active = st_reg.shadow;
    end
    // Read returns the last value written; unmapped reads zero
    case (rdAddr)
      `DCR_ADDR_FTW: st_next.rdData = st_reg.shadow.ftw;
      `DCR_ADDR_POW: st_next.rdData = st_reg.shadow.pow;
      `DCR_ADDR_AMP: st_next.rdData = st_reg.shadow.ampCtl;
      `DCR_ADDR_SWRATE: st_next.rdData = st_reg.shadow.sweepRates;
      `DCR_ADDR_RISE: st_next.rdData = st_reg.shadow.riseDelta;
      `DCR_ADDR_FALL: st_next.rdData = st_reg.shadow.fallDelta;
      default: st_next.rdData = `DCR_READ_NONE;
    endcase
    if (!sweepEn) begin
      st_next.sweepAcc = '0;
    end else if (sweepTick && sweepUp) begin
      st_next.sweepAcc = st_reg.sweepAcc + st_reg.active.riseDelta;
    end else if (sweepTick) begin
      st_next.sweepAcc = st_reg.sweepAcc - st_reg.active.fallDelta;
    end
    if (!autoRamp) begin
      st_next.ampNow = `DCR_AMP_ZERO;
    end else if (ampTick && amplitudeRamping) begin
      ampSum = {1'b0, st_reg.ampNow} + stepSize;
      st_next.ampNow = (ampSum > {1'b0, scale}) ? scale : ampSum[9:0];
    end else if (ampTick) begin
      st_next.ampNow = ({1'b0, st_reg.ampNow} > stepSize) ?
        st_reg.ampNow - stepSize[9:0] : `DCR_AMP_ZERO;
    end
    if (mulEn) begin
      st_next.sampleOut = product[19:`DCR_SCALE_SHIFT];
    end else begin
      st_next.sampleOut = coreSample;
    end
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs taken from flops or the active bank; freqWord adds sweepAcc to the active tuning word
  assign rdData = st_reg.rdData;
  assign sampleOut = st_reg.sampleOut;
  assign phaseOffset = st_reg.active.pow[13:0];
  assign freqWord = st_reg.active.ftw + st_reg.sweepAcc;

  ////////////////////////////////////////////////////////////////////
  sequence s_update_seen;
    ce && updatePulse;
  endsequence
  sequence s_ftw_write;
    ce && hostWr.wr && hostWr.addr == `DCR_ADDR_FTW;
  endsequence

  a_update_copies: assert property (@(posedge clock) disable iff (!arst_n)
    s_update_seen |=> st_reg.active == $past(st_reg.shadow))
    else $error("active bank not loaded on update");
  a_active_holds: assert property (@(posedge clock) disable iff (!arst_n)
    !updatePulse |=> st_reg.active == $past(st_reg.active))
    else $error("active bank changed without update");
  a_ftw_reaches: assert property (@(posedge clock) disable iff (!arst_n)
    s_ftw_write ##1 s_update_seen |=> st_reg.active.ftw ==
    $past(hostWr.data, 2))
    else $error("tuning word not applied after update");
  a_pow_open: assert property (@(posedge clock) disable iff (!arst_n)
    st_reg.shadow.pow[15:14] == 2'h0)
    else $error("phase offset open bits set");
  a_acr_open: assert property (@(posedge clock) disable iff (!arst_n)
    st_reg.shadow.ampCtl[`DCR_AMPC_OPEN] == 1'h0)
    else $error("amplitude control open bit set");
  a_sample_bypass: assert property (@(posedge clock) disable iff (!arst_n)
    ce && !mulEn |=> sampleOut == $past(coreSample))
    else $error("sample not bypassed with multiplier off");
  a_manual_still: assert property (@(posedge clock) disable iff (!arst_n)
    ce && !autoRamp |=> st_reg.ampNow == 10'h000)
    else $error("amplitude ramp moved in manual mode");
  a_sweep_rise: assert property (@(posedge clock) disable iff (!arst_n)
    ce && sweepEn && sweepTick && sweepUp |=> st_reg.sweepAcc ==
    $past(st_reg.sweepAcc) + $past(st_reg.active.riseDelta))
    else $error("rising delta not added");
  a_sweep_fall: assert property (@(posedge clock) disable iff (!arst_n)
    ce && sweepEn && sweepTick && !sweepUp |=> st_reg.sweepAcc ==
    $past(st_reg.sweepAcc) - $past(st_reg.active.fallDelta))
    else $error("falling delta not subtracted");
  a_sweep_idle: assert property (@(posedge clock) disable iff (!arst_n)
    ce && !sweepEn |=> st_reg.sweepAcc == 32'h0)
    else $error("sweep offset kept while sweep off");
  a_rise_rate: assert property (@(posedge clock) disable iff (!arst_n)
    sweepUp |-> sweepRate ==
    st_reg.active.sweepRates[`DCR_SWR_RISE_HI:`DCR_SWR_RISE_LO])
    else $error("rising sweep rate taken from wrong byte");
endmodule

//--- hdl/dcr_map.svh
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
// Register addresses on the host write/read port
`define DCR_ADDR_FTW 5'h04
`define DCR_ADDR_POW 5'h05
`define DCR_ADDR_AMP 5'h06
`define DCR_ADDR_SWRATE 5'h07
`define DCR_ADDR_RISE 5'h08
`define DCR_ADDR_FALL 5'h09
// Writable bits; open bits are stored and read as zero
`define DCR_MASK_FULL 32'hFFFFFFFF
`define DCR_MASK_POW 32'h00003FFF
`define DCR_MASK_AMP 32'h00FFDFFF
`define DCR_MASK_SWRATE 32'h0000FFFF
`define DCR_RESET_VAL 32'h00000000
`define DCR_READ_NONE 32'h00000000
// Amplitude control field positions
`define DCR_AMPC_RATE_HI 23
`define DCR_AMPC_RATE_LO 16
`define DCR_AMPC_STEP_HI 15
`define DCR_AMPC_STEP_LO 14
`define DCR_AMPC_OPEN 13
`define DCR_AMPC_MUL_EN 12
`define DCR_AMPC_AUTO 11
`define DCR_AMPC_RELOAD 10
`define DCR_AMPC_SCALE_HI 9
`define DCR_AMPC_SCALE_LO 0
// Sweep ramp rate field positions
`define DCR_SWR_FALL_HI 15
`define DCR_SWR_FALL_LO 8
`define DCR_SWR_RISE_HI 7
`define DCR_SWR_RISE_LO 0
// Scaling and timer constants
`define DCR_STEP_ONE 11'h001
`define DCR_AMP_ZERO 10'h000
`define DCR_SCALE_SHIFT 10
`define DCR_SYNC_ZERO 3'h0
`define DCR_TIMER_ONE 1
`endif

//--- hdl/dcr_pkg.sv
package dcr_pkg;
  // One host write request from the serial port decoder
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [31:0] data;
  } dcr_wr_t;

  // One channel's set of registers, each held in a full word
  typedef struct packed {
    logic [31:0] ftw;
    logic [31:0] pow;
    logic [31:0] ampCtl;
    logic [31:0] sweepRates;
    logic [31:0] riseDelta;
    logic [31:0] fallDelta;
  } dcr_bank_t;

  // Whole state of the channel bank
  typedef struct packed {
    dcr_bank_t shadow;
    dcr_bank_t active;
    logic [2:0] updSync;
    logic updLvl;
    logic [31:0] sweepAcc;
    logic [9:0] ampNow;
    logic [31:0] rdData;
    logic [9:0] sampleOut;
  } dcr_state_t;
endpackage

//--- hdl/dcr_ramp_timer.sv
`timescale 1ns/1ns
`include "dcr_map.svh"
module dcr_ramp_timer #(
  parameter int W = 8
) (
  input wire logic clock, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic run, // Timer counts while high
  input wire logic [W-1:0] rate, // Reload value
  input wire logic reloadOnUpd, // Also reload on update strobe
  input wire logic update, // Update strobe pulse
  output logic tick // Timeout, one cycle per period
);
  import dcr_pkg::*;

  typedef struct packed {
    logic [W-1:0] count;
  } dcr_tmr_t;

  dcr_tmr_t st_reg;
  dcr_tmr_t st_next;
  localparam logic [W-1:0] ONE = W'(`DCR_TIMER_ONE);

  ////////////////////////////////////////////////////////////////////
  // A zero rate behaves as one so the timer never stalls
  always_comb begin
    st_next = st_reg;
    tick = run && (st_reg.count <= ONE);
    if (!run) begin
      st_next.count = rate;
    end else if (tick || (reloadOnUpd && update)) begin
      st_next.count = rate;
    end else begin
      st_next.count = st_reg.count - ONE;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_reload_timeout: assert property (@(posedge clock) disable iff (!arst_n)
    ce && run && st_reg.count == ONE |=> st_reg.count == $past(rate))
    else $error("timer did not reload on timeout");
  a_reload_update: assert property (@(posedge clock) disable iff (!arst_n)
    ce && run && reloadOnUpd && update |=> st_reg.count == $past(rate))
    else $error("timer did not reload on update");
  a_hold_count: assert property (@(posedge clock) disable iff (!arst_n)
    ce && run && !reloadOnUpd && st_reg.count > ONE
    |=> st_reg.count == $past(st_reg.count) - ONE)
    else $error("timer reloaded without timeout");
endmodule

//--- bench/dcr_host_model.sv
`timescale 1ns/1ns
module dcr_host_model (
  input wire logic clock, // System clock
  input wire logic [31:0] rdData, // Read data from the bank
  output dcr_pkg::dcr_wr_t hostWr, // Write request to the bank
  output logic [4:0] rdAddr, // Read address to the bank
  output logic updatePin // Update strobe pin
);
  import dcr_pkg::*;
  // Idle host: no write, strobe low
  initial begin
    hostWr = '0;
    rdAddr = 5'h00;
    updatePin = 1'b0;
  end
  // One write, offered for exactly one taking edge
  task automatic write_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    hostWr <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clock);
    hostWr.wr <= 1'b0;
  endtask
  // Read word lands on the same edge that samples the address
  task automatic read_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    rdAddr <= a;
    @(posedge clock);
    #1 d = rdData;
  endtask
  // Strobe held over three sampling edges so the filter accepts it
  task automatic pulse_update();
    @(posedge clock);
    updatePin <= 1'b1;
    repeat (3) @(posedge clock);
    updatePin <= 1'b0;
  endtask
endmodule

//--- bench/dcr_channel_regs_bench.sv
`timescale 1ns/1ns
`include "dcr_map.svh"
module dcr_channel_regs_bench;
  import dcr_pkg::*;
  logic clock, arst_n, ce, updatePin, sweepEn, sweepReload, sweepUp;
  logic amplitudeRamping, ampClkEn, updatePulse;
  dcr_wr_t hostWr;
  logic [4:0] rdAddr;
  logic [9:0] coreSample, sampleOut;
  logic [31:0] rdData, freqWord;
  logic [13:0] phaseOffset;
  int errCount = 0, nCompared = 0, cycles = 0, nPulse = 0;
  dcr_channel_regs u_dut (.clock(clock), .arst_n(arst_n), .ce(ce),
    .hostWr(hostWr), .rdAddr(rdAddr), .updatePin(updatePin),
    .sweepEn(sweepEn), .sweepReload(sweepReload), .sweepUp(sweepUp),
    .amplitudeRamping(amplitudeRamping), .coreSample(coreSample),
    .rdData(rdData), .freqWord(freqWord), .phaseOffset(phaseOffset),
    .sampleOut(sampleOut), .ampClkEn(ampClkEn), .updatePulse(updatePulse));
  dcr_host_model u_host (.clock(clock), .rdData(rdData), .hostWr(hostWr),
    .rdAddr(rdAddr), .updatePin(updatePin));
  //////////////////////////////////////////////////////////////////////////
  // Clock, strobe counter and hang guard; full run is about 150 cycles
  initial clock = 1'b0;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (updatePulse === 1'b1) nPulse++;
    if (cycles == 5000) begin
      errCount++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (errCount == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] cur(input bit smp);
    return smp ? {22'h0, sampleOut} : freqWord;
  endfunction
  // Third gap between changes, so timer phase after a switch is flushed
  task automatic period_of(input bit smp, output logic [31:0] per,
                           output logic [31:0] dlt);
    logic [31:0] v0, v1;
    int n;
    for (int k = 0; k < 3; k++) begin
      v0 = cur(smp);
      n = 0;
      do begin
        @(posedge clock);
        #1 n++;
        v1 = cur(smp);
      end while (v1 === v0 && n < 60);
    end
    per = 32'(n);
    dlt = v1 - v0;
  endtask
  task automatic strobe();
    u_host.pulse_update();
    repeat (3) @(posedge clock);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // All-ones through each register address and one unmapped one shows which bits each place keeps
  task automatic t_regs();
    logic [31:0] d;
    logic [31:0] m[7] = '{32'hFFFFFFFF, 32'h00003FFF, 32'h00FFDFFF,
      32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000};
    u_host.read_reg(`DCR_ADDR_FTW, d);
    chk(d, 32'h00000000); // reset value
    for (int i = 0; i < 7; i++) u_host.write_reg(5'(i + 4), 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) begin
      u_host.read_reg(5'(i + 4), d);
      chk(d, m[i]);
    end
    @(posedge clock);
    ce <= 1'b0;
    u_host.write_reg(`DCR_ADDR_FTW, 32'h00000000);
    ce <= 1'b1;
    u_host.read_reg(`DCR_ADDR_FTW, d);
    chk(d, 32'hFFFFFFFF); // frozen write
  endtask
  // New words stay hidden until one strobe moves them together
  task automatic t_update();
    int p;
    u_host.write_reg(`DCR_ADDR_FTW, 32'h12345678);
    u_host.write_reg(`DCR_ADDR_POW, 32'h0000ABCD);
    chk(freqWord, 32'h00000000); // held back
    p = nPulse;
    strobe();
    chk(32'(nPulse - p), 32'h1); // single pulse
    chk(freqWord, 32'h12345678);
    chk({18'h0, phaseOffset}, 32'h00002BCD); // open bits dropped
  endtask
  // Bypass, bypass with auto bit alone, manual half scale
  task automatic t_sample();
    logic [31:0] a[3] = '{32'h00000000, 32'h00040BFF, 32'h00001200};
    logic [31:0] s[3] = '{32'h3FF, 32'h3FF, 32'h1FF};
    for (int i = 0; i < 3; i++) begin
      u_host.write_reg(`DCR_ADDR_AMP, a[i]);
      strobe();
      chk({22'h0, sampleOut}, s[i]);
      chk({31'h0, ampClkEn}, 32'(i == 2));
    end
  endtask
  // Rising step 5 every 3 cycles, then falling step 7 every 2
  task automatic t_sweep();
    logic [31:0] per, dlt;
    u_host.write_reg(`DCR_ADDR_FTW, 32'h00000064);
    u_host.write_reg(`DCR_ADDR_RISE, 32'h00000005);
    u_host.write_reg(`DCR_ADDR_FALL, 32'h00000007);
    u_host.write_reg(`DCR_ADDR_SWRATE, 32'h00000203);
    strobe();
    // Enable after the update so the idle timer holds the new rate
    @(posedge clock);
    sweepEn <= 1'b1;
    period_of(1'b0, per, dlt);
    chk(per, 32'h3);
    chk(dlt, 32'h5);
    @(posedge clock);
    sweepUp <= 1'b0;
    period_of(1'b0, per, dlt);
    chk(per, 32'h2);
    chk(dlt, 32'hFFFFFFF9);
    @(posedge clock);
    sweepEn <= 1'b0;
  endtask
  // Auto ramp at rate 4, step 1, both directions
  task automatic t_auto();
    logic [31:0] per, dlt;
    u_host.write_reg(`DCR_ADDR_AMP, 32'h00041BFF);
    strobe();
    period_of(1'b1, per, dlt);
    chk(per, 32'h4);
    chk(dlt, 32'h1);
    @(posedge clock);
    amplitudeRamping <= 1'b0;
    period_of(1'b1, per, dlt);
    chk(per, 32'h4);
    chk(dlt, 32'hFFFFFFFF);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Reset held four cycles, then the scenarios in turn
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    sweepEn = 1'b0;
    sweepReload = 1'b0;
    sweepUp = 1'b1;
    amplitudeRamping = 1'b1;
    coreSample = 10'h3FF;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_update();
    t_sample();
    t_sweep();
    t_auto();
    tally_and_finish();
  end
endmodule
